// ### hdl/hbfp_stage.sv
// Purpose: Fault protection and clear control for three half-bridges of a motor power stage.
// Assumes: Comparator indications are active-high levels from analog monitors.
// Notes: A half-bridge in high impedance has both gate enables low.
// Contract
// - Warning output low above warning level, outputs run.
// - Thermal shutdown tristates all bridges, fault low.
// - Thermal latch persists until all clears low or each clear has risen.
// - Power-on clear resets overcurrent, holds outputs off.
// - Undervoltage tristates all bridges immediately, fault low.
// - Undervoltage recovers automatically, no latch.
// - Low clear input tristates its own bridge.
// - Cycle-limit latch cleared by own clear rising.
// - Thermal or latching trip needs all three rises.
// - Two policies: cycle limit or latching shutdown.
// - Policy select zero chooses cycle limiting.
// - Controller gives minimum low-side pulse per period.
// - Controller switches phases complementarily.
// - Two-quadrant use should pick latching policy.
// - Cycle limiting: high-side trip forces low-side; low-side trip tristates. Latching policy tristates on either trip.
// - Constant input after trip keeps bridge tristated.
// - Fault and warning pins encode four states.
`default_nettype none
module hbfp_stage
    import hbfp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    hbfp_link_if.stage link,
    input wire logic temp_over_warn,
    input wire logic temp_over_shut,
    input wire logic supply_undervoltage,
    input wire logic [2:0] oc_high_side,
    input wire logic [2:0] oc_low_side,
    output logic [2:0] gate_high,
    output logic [2:0] gate_low,
    output logic [2:0] bridge_off
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [2:0] pwm_s, clr_s, ohs_s, ols_s;
    logic tw_s, ts_s, uv_s, pol_s;
    hbfp_sync #(.W(3), .RST_VAL(3'h0)) u_sync_pwm (.pclk(pclk), .presetn(presetn), .d(link.pwm), .q(pwm_s));
    hbfp_sync #(.W(3), .RST_VAL(3'h0)) u_sync_clr (.pclk(pclk), .presetn(presetn), .d(link.clear_n), .q(clr_s));
    hbfp_sync #(.W(3), .RST_VAL(3'h0)) u_sync_ohs (.pclk(pclk), .presetn(presetn), .d(oc_high_side), .q(ohs_s));
    hbfp_sync #(.W(3), .RST_VAL(3'h0)) u_sync_ols (.pclk(pclk), .presetn(presetn), .d(oc_low_side), .q(ols_s));
    hbfp_sync #(.W(4), .RST_VAL(4'h1)) u_sync_misc (.pclk(pclk), .presetn(presetn),
        .d({temp_over_warn, temp_over_shut, supply_undervoltage, link.limit_policy_select}),
        .q({tw_s, ts_s, uv_s, pol_s}));

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        hbfp_br_state_t [2:0] br;
        logic [2:0] clr_d;
        logic [2:0] pwm_d;
        logic [2:0] rose;
        logic thermal_shutdown;
        logic [2:0] gh;
        logic [2:0] gl;
        logic [2:0] off;
        logic fault_n;
        logic warn_n;
    } hbfp_stage_st_t;
    hbfp_stage_st_t st_r, st_nxt;

    logic cycle_limit_mode;
    assign cycle_limit_mode = !pol_s;

    always_comb begin
        logic [2:0] clr_rise;
        logic any_latched;
        logic any_oc;
        clr_rise = clr_s & ~st_r.clr_d;
        any_latched = 1'b0;
        any_oc = 1'b0;
        st_nxt = st_r;
        st_nxt.clr_d = clr_s;
        st_nxt.pwm_d = pwm_s;
        st_nxt.rose = st_r.rose | clr_rise;
        // Thermal latch: set above shutdown level, cleared while all clears are low.
        if (ts_s) begin
            st_nxt.thermal_shutdown = 1'b1;
        end else if (clr_s == 3'h0) begin
            st_nxt.thermal_shutdown = 1'b0;
        end
        for (int i = 0; i < HBFP_NUM_BRIDGES; i++) begin
            unique case (st_r.br[i])
                HBFP_BR_RUN: begin
                    if (ohs_s[i] || ols_s[i]) begin
                        st_nxt.br[i] = cycle_limit_mode ? HBFP_BR_LIMIT : HBFP_BR_LATCHED;
                    end
                end
                HBFP_BR_LIMIT: begin
                    // Limiting ends at the next PWM edge; a held input keeps the bridge off.
                    if (pwm_s[i] != st_r.pwm_d[i]) begin
                        st_nxt.br[i] = HBFP_BR_RUN;
                    end else if (!ohs_s[i] && !ols_s[i]) begin
                        st_nxt.br[i] = HBFP_BR_WAIT_EDGE;
                    end
                end
                HBFP_BR_WAIT_EDGE: begin
                    if (pwm_s[i] != st_r.pwm_d[i]) begin
                        st_nxt.br[i] = HBFP_BR_RUN;
                    end
                end
                HBFP_BR_LATCHED: begin
                    if (cycle_limit_mode && clr_rise[i]) begin
                        st_nxt.br[i] = HBFP_BR_RUN;
                    end
                end
                default: st_nxt.br[i] = HBFP_BR_LATCHED;
            endcase
            if (st_r.br[i] == HBFP_BR_LATCHED) begin
                any_latched = 1'b1;
            end
            if (st_r.br[i] == HBFP_BR_LIMIT && ohs_s[i] && ols_s[i]) begin
                any_oc = 1'b1;
            end
        end
        // Latching-policy or thermal faults need a rise on every clear since the fault.
        if ((st_r.thermal_shutdown || (any_latched && !cycle_limit_mode)) && st_r.rose == 3'h7) begin
            st_nxt.rose = 3'h0;
            if (!ts_s) begin
                st_nxt.thermal_shutdown = 1'b0;
            end
            for (int i = 0; i < HBFP_NUM_BRIDGES; i++) begin
                if (st_r.br[i] == HBFP_BR_LATCHED) begin
                    st_nxt.br[i] = HBFP_BR_RUN;
                end
            end
        end else if (!st_r.thermal_shutdown && !any_latched) begin
            st_nxt.rose = 3'h0;
        end
        // A short that stays through limiting escalates to a latched trip.
        for (int i = 0; i < HBFP_NUM_BRIDGES; i++) begin
            if (st_r.br[i] == HBFP_BR_LIMIT && ohs_s[i] && ols_s[i]) begin
                st_nxt.br[i] = HBFP_BR_LATCHED;
            end
        end
        // Gate drive per bridge.
        for (int i = 0; i < HBFP_NUM_BRIDGES; i++) begin
            st_nxt.gh[i] = pwm_s[i];
            st_nxt.gl[i] = !pwm_s[i];
            if (st_nxt.br[i] == HBFP_BR_LIMIT) begin
                st_nxt.gh[i] = 1'b0;
                st_nxt.gl[i] = !ols_s[i] && ohs_s[i];
            end
            if (st_nxt.br[i] == HBFP_BR_WAIT_EDGE || st_nxt.br[i] == HBFP_BR_LATCHED || !clr_s[i] || uv_s
                || st_nxt.thermal_shutdown) begin
                st_nxt.gh[i] = 1'b0;
                st_nxt.gl[i] = 1'b0;
            end
            st_nxt.off[i] = !st_nxt.gh[i] && !st_nxt.gl[i];
        end
        st_nxt.fault_n = !(uv_s || st_nxt.thermal_shutdown || any_latched || any_oc);
        st_nxt.warn_n = !tw_s;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Power-on clear: overcurrent state reset, bridges off, fault shown.
            st_r.br <= {HBFP_BR_RUN, HBFP_BR_RUN, HBFP_BR_RUN};
            st_r.clr_d <= 3'h0;
            st_r.pwm_d <= 3'h0;
            st_r.rose <= 3'h0;
            st_r.thermal_shutdown <= 1'b0;
            st_r.gh <= 3'h0;
            st_r.gl <= 3'h0;
            st_r.off <= 3'h7;
            st_r.fault_n <= 1'b0;
            st_r.warn_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gate_high = st_r.gh;
    assign gate_low = st_r.gl;
    assign bridge_off = st_r.off;
    assign link.fault_n = st_r.fault_n;
    assign link.temp_warning_n = st_r.warn_n;
endmodule
`default_nettype wire

// ### hdl/hbfp_pkg.sv
// Purpose: Shared constants and types for the half-bridge fault protection block.
// Assumes: One system clock pclk at 100 MHz, asynchronous active-low reset presetn.
// Notes: Both ends import this package; the interface does not.
`default_nettype none
package hbfp_pkg;
    localparam int HBFP_NUM_BRIDGES = 3;
    // Controller register offsets on its APB port.
    localparam logic [7:0] HBFP_OFF_CTRL = 8'h00;
    localparam logic [7:0] HBFP_OFF_PWM = 8'h04;
    localparam logic [7:0] HBFP_OFF_STATUS = 8'h08;
    localparam logic [7:0] HBFP_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] HBFP_OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] HBFP_OFF_IRQ_EN = 8'h14;
    // Field positions in the control register.
    localparam int HBFP_CTRL_CLEAR_POS = 0;
    localparam int HBFP_CTRL_POLICY_POS = 3;
    // Interrupt bit positions.
    localparam int HBFP_IRQ_FAULT_POS = 0;
    localparam int HBFP_IRQ_WARN_POS = 1;
    localparam int HBFP_IRQ_W = 2;
    // Reset values.
    localparam logic [2:0] HBFP_CLEAR_RST = 3'h0;
    localparam logic HBFP_POLICY_RST = 1'b0;
    // Minimum low-side pulse per period, in ns, and its cycle count at 100 MHz.
    localparam int HBFP_CLK_PERIOD_NS = 10;
    localparam int HBFP_MIN_LS_NS = 100;
    localparam int HBFP_MIN_LS_CYC = (HBFP_MIN_LS_NS + HBFP_CLK_PERIOD_NS - 1) / HBFP_CLK_PERIOD_NS;
    localparam int HBFP_PWM_CNT_W = 8;
    // Half-bridge drive states.
    typedef enum logic [3:0] {
        HBFP_BR_RUN = 4'b0001,
        HBFP_BR_LIMIT = 4'b0010,
        HBFP_BR_WAIT_EDGE = 4'b0100,
        HBFP_BR_LATCHED = 4'b1000
    } hbfp_br_state_t;
endpackage
`default_nettype wire

// ### hdl/hbfp_link_if.sv
// Purpose: Pins between the power stage protection logic and the motor controller.
// Assumes: All signals synchronous to the shared system clock.
// Notes: High-impedance of a half-bridge is shown as both gate enables low.
`default_nettype none
interface hbfp_link_if;
    logic [2:0] pwm;
    logic [2:0] clear_n;
    logic limit_policy_select;
    logic fault_n;
    logic temp_warning_n;
    modport stage (input pwm, input clear_n, input limit_policy_select, output fault_n, output temp_warning_n);
    modport ctrl (output pwm, output clear_n, output limit_policy_select, input fault_n, input temp_warning_n);
endinterface
`default_nettype wire

// ### hdl/hbfp_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Inputs may change at any time relative to pclk.
// Notes: The first stage feeds only the second.
`default_nettype none
module hbfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hbfp_sync_st_t;
    hbfp_sync_st_t st_r, st_nxt;
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.s2;
endmodule
`default_nettype wire

// ### hdl/hbfp_ctrl.sv
// Purpose: Motor controller end: drives PWM, clears and policy select from APB registers.
// Assumes: APB slave with zero wait states, 32-bit data.
// Notes: Each PWM phase gets a guaranteed low-side interval every period.
`default_nettype none
module hbfp_ctrl
    import hbfp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    hbfp_link_if.ctrl link
);
    typedef struct packed {
        logic [2:0] clear_n;
        logic policy;
        logic [2:0] pwm_req;
        logic [2:0] pwm;
        logic [HBFP_PWM_CNT_W-1:0] ls_cnt;
        logic [HBFP_IRQ_W-1:0] irq_stat;
        logic [HBFP_IRQ_W-1:0] irq_en;
        logic [1:0] pin_d;
        logic [31:0] rdata;
        logic slverr;
        logic irq;
    } hbfp_ctrl_st_t;
    hbfp_ctrl_st_t st_r, st_nxt;

    // Tells whether an address is mapped for the given direction; the clear register is write-only.
    function automatic logic addr_ok(input logic [7:0] a, input logic w);
        if (w) begin
            return a inside {HBFP_OFF_CTRL, HBFP_OFF_PWM, HBFP_OFF_STATUS, HBFP_OFF_IRQ_STAT, HBFP_OFF_IRQ_CLR,
                HBFP_OFF_IRQ_EN};
        end
        return a inside {HBFP_OFF_CTRL, HBFP_OFF_PWM, HBFP_OFF_STATUS, HBFP_OFF_IRQ_STAT, HBFP_OFF_IRQ_EN};
    endfunction

    always_comb begin
        logic acc;
        logic [HBFP_IRQ_W-1:0] ev;
        acc = psel && penable;
        ev = '0;
        st_nxt = st_r;
        st_nxt.pin_d = {link.temp_warning_n, link.fault_n};
        ev[HBFP_IRQ_FAULT_POS] = st_r.pin_d[0] && !link.fault_n;
        ev[HBFP_IRQ_WARN_POS] = st_r.pin_d[1] && !link.temp_warning_n;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata = 32'h0;
        if (acc && pwrite) begin
            unique case (paddr)
                HBFP_OFF_CTRL: begin
                    st_nxt.clear_n = pwdata[HBFP_CTRL_CLEAR_POS +: 3];
                    st_nxt.policy = pwdata[HBFP_CTRL_POLICY_POS];
                end
                HBFP_OFF_PWM: st_nxt.pwm_req = pwdata[2:0];
                HBFP_OFF_IRQ_CLR: st_nxt.irq_stat = st_r.irq_stat & ~pwdata[HBFP_IRQ_W-1:0];
                HBFP_OFF_IRQ_EN: st_nxt.irq_en = pwdata[HBFP_IRQ_W-1:0];
                default: st_nxt.slverr = st_r.slverr;
            endcase
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                HBFP_OFF_CTRL: st_nxt.rdata = {28'h0, st_r.policy, st_r.clear_n};
                HBFP_OFF_PWM: st_nxt.rdata = {29'h0, st_r.pwm_req};
                HBFP_OFF_STATUS: st_nxt.rdata = {29'h0, st_r.pwm};
                HBFP_OFF_IRQ_STAT: st_nxt.rdata = {30'h0, st_r.irq_stat};
                HBFP_OFF_IRQ_EN: st_nxt.rdata = {30'h0, st_r.irq_en};
                default: st_nxt.rdata = 32'h0;
            endcase
        end else if (psel && !penable) begin
            st_nxt.rdata = 32'h0;
        end else begin
            st_nxt.rdata = st_r.rdata;
        end
        // The error response is decided in the setup cycle so it stands at the access edge.
        if (psel && !penable) begin
            st_nxt.slverr = !addr_ok(paddr, pwrite);
        end else if (acc) begin
            st_nxt.slverr = st_r.slverr;
        end
        st_nxt.irq_stat = st_nxt.irq_stat | ev; // Set wins over clear.
        // Low-side hold: a falling request starts the counter; rises wait until it ends.
        for (int i = 0; i < HBFP_NUM_BRIDGES; i++) begin
            if (!st_r.pwm[i] || st_r.ls_cnt != '0) begin
                st_nxt.pwm[i] = (st_r.ls_cnt == '0) ? st_r.pwm_req[i] : 1'b0;
            end else begin
                st_nxt.pwm[i] = st_r.pwm_req[i];
            end
        end
        if ((st_r.pwm & ~st_nxt.pwm) != 3'h0) begin
            st_nxt.ls_cnt = HBFP_PWM_CNT_W'(HBFP_MIN_LS_CYC);
        end else if (st_r.ls_cnt != '0) begin
            st_nxt.ls_cnt = st_r.ls_cnt - 1'b1;
        end
        st_nxt.irq = (st_nxt.irq_stat & st_nxt.irq_en) != '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.clear_n <= HBFP_CLEAR_RST;
            st_r.policy <= HBFP_POLICY_RST;
            st_r.pwm_req <= 3'h0;
            st_r.pwm <= 3'h0;
            st_r.ls_cnt <= '0;
            st_r.irq_stat <= '0;
            st_r.irq_en <= '0;
            st_r.pin_d <= 2'h3;
            st_r.rdata <= 32'h0;
            st_r.slverr <= 1'b0;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = st_r.slverr;
    assign irq = st_r.irq;
    assign link.pwm = st_r.pwm;
    assign link.clear_n = st_r.clear_n;
    assign link.limit_policy_select = st_r.policy;
endmodule
`default_nettype wire

// ### sim/hbfp_checker.sv
// Purpose: Concurrent checks on the link pins and gate drive of the protection stage.
// Assumes: One clock pclk, presetn asynchronous active low.
// Notes: Conditions are held four samples so the synchroniser delay is covered.
`default_nettype none
module hbfp_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] pwm,
    input wire logic [2:0] clear_n,
    input wire logic fault_n,
    input wire logic temp_warning_n,
    input wire logic temp_over_warn,
    input wire logic temp_over_shut,
    input wire logic supply_undervoltage,
    input wire logic [2:0] oc_high_side,
    input wire logic [2:0] oc_low_side,
    input wire logic [2:0] gate_high,
    input wire logic [2:0] gate_low,
    input wire logic [2:0] bridge_off
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ********************
    // Sequences
    // ********************
    // Nothing that could release a latched fault happens for eight samples.
    sequence s_quiet;
        (clear_n == 3'h7 && !supply_undervoltage && (oc_high_side | oc_low_side) == 3'h0 && $stable(pwm)) [*8];
    endsequence
    sequence s_hot;
        temp_over_shut [*4];
    endsequence
    // ********************
    // Assertions
    // ********************
    a_warn_follows_temp: assert property (temp_over_warn [*4] |=> !temp_warning_n)
        else $error("warning output not low while warm");
    a_shut_tristates: assert property (s_hot |=> bridge_off == 3'h7 && !fault_n)
        else $error("thermal shutdown did not tristate all bridges");
    a_uv_tristates: assert property (supply_undervoltage [*4] |=> bridge_off == 3'h7 && !fault_n)
        else $error("undervoltage did not tristate all bridges");
    a_fault_latched: assert property (s_quiet ##0 !fault_n |=> !fault_n)
        else $error("latched fault released without clear edges");
    for (genvar i = 0; i < 3; i++) begin : g_br
        a_clear_tristate: assert property (!clear_n[i] [*4] |=> bridge_off[i])
            else $error("low clear input did not tristate its bridge");
        a_hz_gates_off: assert property (bridge_off[i] |-> !gate_high[i] && !gate_low[i])
            else $error("gate enabled on a tristated bridge");
        a_oc_high_cut: assert property (oc_high_side[i] [*4] |=> !gate_high[i])
            else $error("high side still on during its overcurrent");
        a_oc_low_cut: assert property (oc_low_side[i] [*4] |=> !gate_low[i])
            else $error("low side still on during its overcurrent");
    end
endmodule
`default_nettype wire

// ### sim/hbfp_tb.sv
// Purpose: Self-checking bench joining the stage and controller ends over the link.
// Assumes: Controller APB answers with zero wait states.
// Notes: Conditions are held eight cycles before outputs are compared.
`default_nettype none
module hbfp_tb
    import hbfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, err, pol;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic temp_over_warn, temp_over_shut, supply_undervoltage;
    logic [2:0] oc_high_side, oc_low_side, gate_high, gate_low, bridge_off;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 63065;
    hbfp_link_if link();
    hbfp_stage hbfp_stage_inst (.pclk(pclk), .presetn(presetn), .link(link), .temp_over_warn(temp_over_warn),
        .temp_over_shut(temp_over_shut), .supply_undervoltage(supply_undervoltage), .oc_high_side(oc_high_side),
        .oc_low_side(oc_low_side), .gate_high(gate_high), .gate_low(gate_low), .bridge_off(bridge_off));
    hbfp_ctrl hbfp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
    hbfp_checker hbfp_checker_inst (.pclk(pclk), .presetn(presetn), .pwm(link.pwm), .clear_n(link.clear_n),
        .fault_n(link.fault_n), .temp_warning_n(link.temp_warning_n), .temp_over_warn(temp_over_warn),
        .temp_over_shut(temp_over_shut), .supply_undervoltage(supply_undervoltage), .oc_high_side(oc_high_side),
        .oc_low_side(oc_low_side), .gate_high(gate_high), .gate_low(gate_low), .bridge_off(bridge_off));
    always #5 pclk = ~pclk;
    // ********************
    // Tasks
    // ********************
    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic env(input logic w, input logic s, input logic u, input logic [2:0] oh, input logic [2:0] ol);
        @(posedge pclk);
        temp_over_warn <= w;
        temp_over_shut <= s;
        supply_undervoltage <= u;
        oc_high_side <= oh;
        oc_low_side <= ol;
        repeat (8) @(posedge pclk);
    endtask
    // Drops the masked clears for one write, then raises all of them.
    task automatic clr_rise(input logic [2:0] m);
        apb(1'b1, HBFP_OFF_CTRL, {28'h0, pol, ~m});
        apb(1'b1, HBFP_OFF_CTRL, {28'h0, pol, 3'h7});
        repeat (8) @(posedge pclk);
    endtask
    function automatic logic [31:0] hz_of(input logic [31:0] c);
        return {29'h0, ~c[2:0]};
    endfunction
    // ********************
    // Main sequence
    // ********************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, pol} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {temp_over_warn, temp_over_shut, supply_undervoltage} = 3'h0;
        {oc_high_side, oc_low_side} = 6'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, HBFP_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk(32'(err), 32'h1);
        clr_rise(3'h7);
        chk(32'({link.fault_n, link.temp_warning_n}), 32'h3);
        apb(1'b1, HBFP_OFF_IRQ_EN, 32'h2);
        env(1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'({link.fault_n, link.temp_warning_n, bridge_off}), 32'h10);
        chk(32'(irq), 32'h1);
        apb(1'b0, HBFP_OFF_IRQ_STAT, 32'h0);
        chk(32'(rd[HBFP_IRQ_WARN_POS]), 32'h1);
        apb(1'b1, HBFP_OFF_IRQ_CLR, 32'h3);
        apb(1'b1, HBFP_OFF_IRQ_EN, 32'h1);
        env(1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
        chk(32'({link.fault_n, bridge_off}), 32'h7);
        chk(32'(irq), 32'h1);
        apb(1'b1, HBFP_OFF_IRQ_EN, 32'h0);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'({link.fault_n, irq}), 32'h2);
        apb(1'b1, HBFP_OFF_IRQ_CLR, 32'h3);
        env(1'b1, 1'b1, 1'b0, 3'h0, 3'h0);
        chk(32'({link.fault_n, link.temp_warning_n, bridge_off}), 32'h7);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'(link.fault_n), 32'h0);
        clr_rise(3'h1);
        clr_rise(3'h2);
        chk(32'(link.fault_n), 32'h0);
        clr_rise(3'h4);
        chk(32'(link.fault_n), 32'h1);
        pol = 1'b1;
        clr_rise(3'h0);
        chk(32'(link.limit_policy_select), 32'h1);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h1);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'({link.fault_n, bridge_off}), 32'h1);
        clr_rise(3'h1);
        chk(32'(link.fault_n), 32'h0);
        clr_rise(3'h7);
        chk(32'({link.fault_n, bridge_off}), 32'h8);
        pol = 1'b0;
        clr_rise(3'h0);
        env(1'b0, 1'b0, 1'b0, 3'h2, 3'h2);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'({link.fault_n, bridge_off[1]}), 32'h1);
        clr_rise(3'h2);
        chk(32'(link.fault_n), 32'h1);
        apb(1'b1, HBFP_OFF_PWM, 32'h7);
        env(1'b0, 1'b0, 1'b0, 3'h4, 3'h0);
        chk(32'(gate_high[2]), 32'h0);
        apb(1'b1, HBFP_OFF_PWM, 32'h0);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h4);
        chk(32'({gate_high[2], gate_low[2]}), 32'h0);
        env(1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
        chk(32'(bridge_off[2]), 32'h1);
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 32'h0 : $random(seed);
            apb(1'b1, HBFP_OFF_PWM, {29'h0, v[6:4]});
            apb(1'b1, HBFP_OFF_CTRL, {29'h0, v[2:0]});
            repeat (8) @(posedge pclk);
            chk(32'(bridge_off & ~v[2:0]), hz_of(v));
        end
        test_done();
    end
    initial begin
        #50000;
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
